/* src/kpd_top.sv */
`timescale 1ns/1ns
module kpd_top #(
  parameter int unsigned DEB_CYCLES    = kpd_pkg::DEB_CYCLES,
  parameter int unsigned SETTLE_CYCLES = kpd_pkg::SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          resetn,
  // register port
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire kpd_pkg::kpd_addr_t            reg_addr,
  input  wire kpd_pkg::kpd_byte_t            reg_wdata,
  output kpd_pkg::kpd_byte_t                 reg_rdata,
  output logic                               reg_rvalid,
  // matrix pins
  input  wire logic [kpd_pkg::NUM_ROWS-1:0]  row_pin,
  output logic      [kpd_pkg::NUM_ROWS-1:0]  row_pullup_en,
  output logic      [kpd_pkg::NUM_COLS-1:0]  col_pin_o,
  output logic      [kpd_pkg::NUM_COLS-1:0]  col_pin_oe,
  // system
  output logic                               board_irq_line_n,
  output logic                               backlight_on,
  output kpd_pkg::kpd_byte_t                 daylight_max_current
);
  import kpd_pkg::*;

  kpd_byte_t            main_q;
  kpd_byte_t            main_d;
  kpd_byte_t            irq_en_q;
  kpd_byte_t            wake_q;
  kpd_byte_t            day_cur_q;
  kpd_byte_t            mode_q;
  kpd_byte_t            func_q;
  kpd_byte_t            pu_q;
  logic [NUM_KEYS-1:0]  press_q;
  logic [NUM_KEYS-1:0]  rel_q;
  logic [NUM_KEYS-1:0]  press_clr;
  logic [NUM_KEYS-1:0]  rel_clr;
  logic [NUM_KEYS-1:0]  key_raw;
  logic [NUM_KEYS-1:0]  key_state;
  logic [NUM_KEYS-1:0]  press_ev;
  logic [NUM_KEYS-1:0]  rel_ev;
  logic [NUM_ROWS-1:0]  row_use;
  logic [NUM_COLS-1:0]  col_use;
  logic [NUM_ROWS-1:0]  pu_out_q;
  kpd_byte_t            rdata_q;
  kpd_byte_t            rd_mux;
  logic                 rvalid_q;
  logic                 irq_n_q;
  logic                 kp3_on;
  logic                 run;
  logic                 press_any;
  logic                 rel_any;
  logic                 wake;
  logic                 wr_main;

  assign run       = main_q[MAIN_RUN_BIT];
  assign press_any = |press_ev;
  assign rel_any   = |rel_ev;
  assign wr_main   = reg_wr && reg_addr == ADDR_MAIN;

  // shared pins only go to the keypad with both mode bits set
  assign kp3_on  = mode_q[MODE_KP_A_BIT] & mode_q[MODE_KP_B_BIT];
  assign row_use = func_q[NUM_ROWS-1:0] & {kp3_on, {(NUM_ROWS-1){1'b1}}};
  assign col_use = func_q[FUNC_COL_LSB +: NUM_COLS] & {kp3_on, {(NUM_COLS-1){1'b1}}};

  // plain configuration registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_en_q <= RST_BYTE;
    end else if (reg_wr && reg_addr == ADDR_IRQ_EN) begin
      irq_en_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_q <= RST_BYTE;
    end else if (reg_wr && reg_addr == ADDR_BL_WAKE) begin
      wake_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      day_cur_q <= RST_BYTE;
    end else if (reg_wr && reg_addr == ADDR_DAY_CUR) begin
      day_cur_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= RST_BYTE;
    end else if (reg_wr && reg_addr == ADDR_PIN_MODE) begin
      mode_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      func_q <= RST_BYTE;
    end else if (reg_wr && reg_addr == ADDR_PIN_FUNC) begin
      func_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pu_q <= RST_BYTE;
    end else if (reg_wr && reg_addr == ADDR_ROW_PU) begin
      pu_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pu_out_q <= '0;
    end else begin
      pu_out_q <= pu_q[NUM_ROWS-1:0];
    end
  end

  // wake only from a first press; a set press master blocks it until cleared
  assign wake = press_any & wake_q[WAKE_EN_BIT] & ~main_q[MAIN_PRESS_BIT];

  always_comb begin
    main_d = main_q;
    if (wr_main) begin
      main_d = (main_q & ~MAIN_RW_MASK) | (reg_wdata & MAIN_RW_MASK);
      main_d[MAIN_PRESS_BIT] = main_q[MAIN_PRESS_BIT] & ~reg_wdata[MAIN_PRESS_BIT];
      main_d[MAIN_REL_BIT]   = main_q[MAIN_REL_BIT] & ~reg_wdata[MAIN_REL_BIT];
    end
    // events win over a clear in the same cycle
    if (press_any) begin
      main_d[MAIN_PRESS_BIT] = 1'b1;
    end
    if (rel_any) begin
      main_d[MAIN_REL_BIT] = 1'b1;
    end
    if (wake) begin
      main_d[MAIN_BL_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      main_q <= RST_BYTE;
    end else begin
      main_q <= main_d;
    end
  end

  // clear on read per byte; a new edge in the same cycle survives
  assign press_clr = {(reg_rd && reg_addr == ADDR_PRESS_HI) ? ALL_ONES_BYTE : ZERO_BYTE,
                      (reg_rd && reg_addr == ADDR_PRESS_LO) ? ALL_ONES_BYTE : ZERO_BYTE};
  assign rel_clr   = {(reg_rd && reg_addr == ADDR_REL_HI) ? ALL_ONES_BYTE : ZERO_BYTE,
                      (reg_rd && reg_addr == ADDR_REL_LO) ? ALL_ONES_BYTE : ZERO_BYTE};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      press_q <= '0;
    end else begin
      press_q <= (press_q & ~press_clr) | press_ev;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rel_q <= '0;
    end else begin
      rel_q <= (rel_q & ~rel_clr) | rel_ev;
    end
  end

  // read data; unmapped offsets read zero
  always_comb begin
    case (reg_addr)
      ADDR_MAIN:     rd_mux = main_q;
      ADDR_IRQ_EN:   rd_mux = irq_en_q;
      ADDR_BL_WAKE:  rd_mux = wake_q;
      ADDR_DAY_CUR:  rd_mux = day_cur_q;
      ADDR_PIN_MODE: rd_mux = mode_q;
      ADDR_PIN_FUNC: rd_mux = func_q;
      ADDR_ROW_PU:   rd_mux = pu_q;
      ADDR_PRESS_LO: rd_mux = press_q[0 +: KEYS_PER_BYTE];
      ADDR_PRESS_HI: rd_mux = press_q[KEYS_PER_BYTE +: KEYS_PER_BYTE];
      ADDR_REL_LO:   rd_mux = rel_q[0 +: KEYS_PER_BYTE];
      ADDR_REL_HI:   rd_mux = rel_q[KEYS_PER_BYTE +: KEYS_PER_BYTE];
      ADDR_STATE_LO: rd_mux = key_state[0 +: KEYS_PER_BYTE];
      ADDR_STATE_HI: rd_mux = key_state[KEYS_PER_BYTE +: KEYS_PER_BYTE];
      default:       rd_mux = ZERO_BYTE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q  <= RST_BYTE;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // level output; goes high once every enabled master bit is cleared
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= ~((main_q[MAIN_PRESS_BIT] & irq_en_q[MAIN_PRESS_BIT]) |
                   (main_q[MAIN_REL_BIT] & irq_en_q[MAIN_REL_BIT]));
    end
  end

  kpd_scan #(
    .SETTLE     (SETTLE_CYCLES)
  ) u_scan (
    .clk        (clk),
    .resetn     (resetn),
    .scan_en    (run),
    .row_use    (row_use),
    .col_use    (col_use),
    .row_pin    (row_pin),
    .col_pin_o  (col_pin_o),
    .col_pin_oe (col_pin_oe),
    .key_raw    (key_raw)
  );

  kpd_debounce #(
    .N        (NUM_KEYS),
    .DEB      (DEB_CYCLES)
  ) u_deb (
    .clk      (clk),
    .resetn   (resetn),
    .raw      (key_raw),
    .stable   (key_state),
    .press_ev (press_ev),
    .rel_ev   (rel_ev)
  );

  assign reg_rdata            = rdata_q;
  assign reg_rvalid           = rvalid_q;
  assign row_pullup_en        = pu_out_q;
  assign board_irq_line_n     = irq_n_q;
  assign backlight_on         = main_q[MAIN_BL_BIT];
  assign daylight_max_current = day_cur_q;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_col3_gate;
    !kp3_on && !$past(kp3_on) |-> !col_pin_oe[NUM_COLS-1];
  endproperty
  a_col3_gate: assert property (p_col3_gate) else $error("column 3 driven outside keypad mode");

  property p_pullup;
    pu_q[0] |=> row_pullup_en[0];
  endproperty
  a_pullup: assert property (p_pullup) else $error("row 0 pull-up not enabled");

  property p_col_func;
    !func_q[FUNC_COL_LSB] && !$past(func_q[FUNC_COL_LSB]) |-> !col_pin_oe[0];
  endproperty
  a_col_func: assert property (p_col_func) else $error("column 0 driven while not a keypad column");

  property p_press_latch;
    press_ev[0] |=> press_q[0];
  endproperty
  a_press_latch: assert property (p_press_latch) else $error("key A press not latched");

  property p_rel_latch;
    rel_ev[0] |=> rel_q[0];
  endproperty
  a_rel_latch: assert property (p_rel_latch) else $error("key A release not latched");

  property p_master;
    press_any && rel_any |=> main_q[MAIN_PRESS_BIT] && main_q[MAIN_REL_BIT];
  endproperty
  a_master: assert property (p_master) else $error("master bit missed an event");

  property p_irq_on;
    main_q[MAIN_REL_BIT] && irq_en_q[MAIN_REL_BIT] |=> !board_irq_line_n;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("enabled release did not interrupt");

  property p_irq_off;
    !(main_q[MAIN_PRESS_BIT] && irq_en_q[MAIN_PRESS_BIT]) && !(main_q[MAIN_REL_BIT] && irq_en_q[MAIN_REL_BIT])
      |=> board_irq_line_n;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt without enabled master");

  property p_rd_clear;
    reg_rd && reg_addr == ADDR_PRESS_LO && press_ev[7:0] == ZERO_BYTE |=> press_q[7:0] == ZERO_BYTE;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("press status not cleared by read");

  property p_w1c;
    wr_main && reg_wdata[MAIN_PRESS_BIT] && !press_any |=> !main_q[MAIN_PRESS_BIT];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear press master");

  property p_w0_keep;
    wr_main && !reg_wdata[MAIN_REL_BIT] && main_q[MAIN_REL_BIT] |=> main_q[MAIN_REL_BIT];
  endproperty
  a_w0_keep: assert property (p_w0_keep) else $error("write zero changed release master");

  property p_wake;
    press_any && wake_q[WAKE_EN_BIT] && !main_q[MAIN_PRESS_BIT] |=> backlight_on;
  endproperty
  a_wake: assert property (p_wake) else $error("press did not wake backlight");

  property p_no_wake;
    press_any && !wake_q[WAKE_EN_BIT] && !backlight_on && !wr_main |=> !backlight_on;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("backlight woke while wake disabled");

  property p_standby;
    !run && !$past(run) |-> col_pin_oe == '0;
  endproperty
  a_standby: assert property (p_standby) else $error("scanning during standby");

  property p_bl_off;
    wr_main && !reg_wdata[MAIN_BL_BIT] && !wake |=> !backlight_on;
  endproperty
  a_bl_off: assert property (p_bl_off) else $error("backlight stayed on after clear");

  property p_day_cur;
    reg_wr && reg_addr == ADDR_DAY_CUR |=> daylight_max_current == $past(reg_wdata);
  endproperty
  a_day_cur: assert property (p_day_cur) else $error("daylight current not taken");

  property p_state_rd;
    reg_rd && reg_addr == ADDR_STATE_LO |=> reg_rvalid && reg_rdata == $past(key_state[7:0]);
  endproperty
  a_state_rd: assert property (p_state_rd) else $error("key state read wrong");

  property p_one_edge;
    press_ev[0] |=> !press_ev[0] && key_state[0];
  endproperty
  a_one_edge: assert property (p_one_edge) else $error("press reported twice");

  c_press: cover property (press_ev[0] ##[1:1000] rel_ev[0]);
  c_irq:   cover property ($fell(board_irq_line_n));
  c_wake:  cover property ($rose(backlight_on));
  c_clear: cover property (reg_rd && reg_addr == ADDR_PRESS_LO && press_q[0]);

endmodule

/* src/kpd_pkg.sv */
package kpd_pkg;

  // clock
  localparam int unsigned CLK_PERIOD_NS  = 4;

  // matrix geometry
  localparam int unsigned NUM_ROWS       = 4;
  localparam int unsigned NUM_COLS       = 4;
  localparam int unsigned NUM_KEYS       = NUM_ROWS * NUM_COLS;
  localparam int unsigned KEYS_PER_BYTE  = 8;

  // timing, least times rounded up to whole cycles
  localparam int unsigned DEB_TIME_NS    = 20000;
  localparam int unsigned DEB_CYCLES     = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_TIME_NS = 100;
  localparam int unsigned SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef logic [7:0] kpd_addr_t;
  typedef logic [7:0] kpd_byte_t;

  // register offsets
  localparam kpd_addr_t ADDR_MAIN     = 8'h00;
  localparam kpd_addr_t ADDR_IRQ_EN   = 8'h01;
  localparam kpd_addr_t ADDR_BL_WAKE  = 8'h02;
  localparam kpd_addr_t ADDR_DAY_CUR  = 8'h05;
  localparam kpd_addr_t ADDR_PIN_MODE = 8'h11;
  localparam kpd_addr_t ADDR_PIN_FUNC = 8'h17;
  localparam kpd_addr_t ADDR_ROW_PU   = 8'h1F;
  localparam kpd_addr_t ADDR_PRESS_LO = 8'h20;
  localparam kpd_addr_t ADDR_PRESS_HI = 8'h21;
  localparam kpd_addr_t ADDR_REL_LO   = 8'h22;
  localparam kpd_addr_t ADDR_REL_HI   = 8'h23;
  localparam kpd_addr_t ADDR_STATE_LO = 8'h24;
  localparam kpd_addr_t ADDR_STATE_HI = 8'h25;

  // field positions
  localparam int unsigned MAIN_PRESS_BIT = 0;
  localparam int unsigned MAIN_REL_BIT   = 1;
  localparam int unsigned MAIN_BL_BIT    = 6;
  localparam int unsigned MAIN_RUN_BIT   = 7;
  localparam int unsigned MODE_KP_A_BIT  = 4;
  localparam int unsigned MODE_KP_B_BIT  = 5;
  localparam int unsigned WAKE_EN_BIT    = 0;
  localparam int unsigned FUNC_COL_LSB   = 4;

  // reset values and masks
  localparam kpd_byte_t RST_BYTE        = 8'h00;
  localparam kpd_byte_t MAIN_RW_MASK    = 8'hC0;
  localparam kpd_byte_t ZERO_BYTE       = 8'h00;
  localparam kpd_byte_t ALL_ONES_BYTE   = 8'hFF;

  typedef enum logic [1:0] {
    SC_OFF    = 2'h0,
    SC_DRIVE  = 2'h1,
    SC_SAMPLE = 2'h3,
    SC_NEXT   = 2'h2
  } kpd_scan_st_t;

endpackage

/* src/kpd_scan.sv */
`timescale 1ns/1ns
module kpd_scan #(
  parameter int unsigned SETTLE = kpd_pkg::SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          resetn,
  // control
  input  wire logic                          scan_en,
  input  wire logic [kpd_pkg::NUM_ROWS-1:0]  row_use,
  input  wire logic [kpd_pkg::NUM_COLS-1:0]  col_use,
  // matrix pins
  input  wire logic [kpd_pkg::NUM_ROWS-1:0]  row_pin,
  output logic      [kpd_pkg::NUM_COLS-1:0]  col_pin_o,
  output logic      [kpd_pkg::NUM_COLS-1:0]  col_pin_oe,
  // result
  output logic      [kpd_pkg::NUM_KEYS-1:0]  key_raw
);
  import kpd_pkg::*;

  localparam int unsigned WW = $clog2(SETTLE + 1);

  kpd_scan_st_t             state_q;
  logic [1:0]               col_q;
  logic [WW-1:0]            wait_q;
  logic [NUM_KEYS-1:0]      acc_q;
  logic [NUM_KEYS-1:0]      key_raw_q;
  logic [NUM_COLS-1:0]      col_oe_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= SC_OFF;
      col_q   <= '0;
      wait_q  <= '0;
    end else if (!scan_en) begin
      state_q <= SC_OFF;
      col_q   <= '0;
      wait_q  <= '0;
    end else begin
      case (state_q)
        SC_OFF: begin
          state_q <= SC_DRIVE;
        end
        SC_DRIVE: begin
          // rows need time to pull back up after a column change
          if (wait_q == WW'(SETTLE - 1)) begin
            wait_q  <= '0;
            state_q <= SC_SAMPLE;
          end else begin
            wait_q <= wait_q + WW'(1);
          end
        end
        SC_SAMPLE: begin
          state_q <= SC_NEXT;
        end
        SC_NEXT: begin
          col_q   <= col_q + 2'h1;
          state_q <= SC_DRIVE;
        end
        default: begin
          state_q <= SC_OFF;
        end
      endcase
    end
  end

  // one column low at a time, only columns given to the keypad
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      col_oe_q <= '0;
    end else if (scan_en && state_q != SC_OFF) begin
      col_oe_q <= NUM_COLS'(4'h1 << col_q) & col_use;
    end else begin
      col_oe_q <= '0;
    end
  end

  // a pressed key pulls its row low through the driven column
  // one register per row so no two processes share a driven vector
  for (genvar r = 0; r < NUM_ROWS; r++) begin : g_row
    logic [NUM_COLS-1:0] hit_q;
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        hit_q <= '0;
      end else if (state_q == SC_SAMPLE) begin
        hit_q[col_q] <= row_use[r] & col_use[col_q] & ~row_pin[r];
      end
    end
    assign acc_q[r*NUM_COLS +: NUM_COLS] = hit_q;
  end

  // publish only whole sweeps so keys never see half a frame
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      key_raw_q <= '0;
    end else if (state_q == SC_NEXT && col_q == 2'(NUM_COLS - 1)) begin
      key_raw_q <= acc_q;
    end
  end

  assign col_pin_o  = '0;
  assign col_pin_oe = col_oe_q;
  assign key_raw    = key_raw_q;

endmodule

/* src/kpd_debounce.sv */
`timescale 1ns/1ns
module kpd_debounce #(
  parameter int unsigned N   = kpd_pkg::NUM_KEYS,
  parameter int unsigned DEB = kpd_pkg::DEB_CYCLES
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          resetn,
  // keys
  input  wire logic [N-1:0]  raw,
  output logic      [N-1:0]  stable,
  output logic      [N-1:0]  press_ev,
  output logic      [N-1:0]  rel_ev
);
  localparam int unsigned CW = $clog2(DEB + 1);

  for (genvar k = 0; k < N; k++) begin : g_key
    logic [CW-1:0] cnt_q;
    logic          st_q;
    logic          pr_q;
    logic          rl_q;
    // a key must hold its new level for the full time before it counts
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        cnt_q <= '0;
        st_q  <= 1'b0;
        pr_q  <= 1'b0;
        rl_q  <= 1'b0;
      end else begin
        pr_q <= 1'b0;
        rl_q <= 1'b0;
        if (raw[k] == st_q) begin
          cnt_q <= '0;
        end else if (cnt_q == CW'(DEB - 1)) begin
          cnt_q <= '0;
          st_q  <= raw[k];
          pr_q  <= raw[k];
          rl_q  <= ~raw[k];
        end else begin
          cnt_q <= cnt_q + CW'(1);
        end
      end
    end
    assign stable[k]   = st_q;
    assign press_ev[k] = pr_q;
    assign rel_ev[k]   = rl_q;
  end

endmodule

/* verification/kpd_keys_model.sv */
`timescale 1ns/1ns
module kpd_keys_model (
  // matrix pins
  input  wire logic [3:0]  col_pin_oe,
  input  wire logic [3:0]  row_pullup_en,
  output logic      [3:0]  row_pin,
  // pressed keys, index row*4+col
  input  wire logic [15:0] keys
);
  logic flip = 1'b0;
  // a row with no pull-up floats: show a changing level, not the last one
  always #4 flip = ~flip;
  always_comb begin
    for (int r = 0; r < 4; r++) begin
      row_pin[r] = row_pullup_en[r] ? 1'b1 : flip;
      for (int c = 0; c < 4; c++)
        if (keys[r*4+c] && col_pin_oe[c]) row_pin[r] = 1'b0;
    end
  end
endmodule

/* verification/kpd_top_tb_top.sv */
`timescale 1ns/1ns
module kpd_top_tb_top;
  import kpd_pkg::*;
  logic       clk       = 1'b0;
  logic       resetn    = 1'b0;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  kpd_addr_t  reg_addr  = 8'h00;
  kpd_byte_t  reg_wdata = 8'h00;
  logic [15:0] keys     = 16'h0000;
  kpd_byte_t  reg_rdata, day_cur, rd_v;
  logic       reg_rvalid, irq_n, bl_on;
  logic [3:0] row_pin, pu_en, col_o, col_oe;
  int         err_total = 0;
  int         n_checks  = 0;

  always #2 clk = ~clk;

  kpd_top #(.DEB_CYCLES(4), .SETTLE_CYCLES(2)) dut (
    .clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .row_pin(row_pin), .row_pullup_en(pu_en),
    .col_pin_o(col_o), .col_pin_oe(col_oe), .board_irq_line_n(irq_n),
    .backlight_on(bl_on), .daylight_max_current(day_cur));

  kpd_keys_model keys_m (
    .col_pin_oe(col_oe), .row_pullup_en(pu_en), .row_pin(row_pin), .keys(keys));

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input kpd_addr_t a, input kpd_byte_t d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask

  // rvalid is looked at in its one cycle, data taken there
  task automatic rd(input kpd_addr_t a);
    reg_rd = 1'b1;
    reg_addr = a;
    step(1);
    reg_rd = 1'b0;
    chk("rvalid", 8'h01, {7'h00, reg_rvalid});
    rd_v = reg_rdata;
    step(1);
  endtask

  // poll the debounced key state, bounded
  task automatic wait_key(input kpd_addr_t a, input kpd_byte_t v);
    for (int i = 0; i < 100; i++) begin
      rd(a);
      if (rd_v === v) return;
    end
    chk("key state", v, rd_v);
    results();
  endtask

  task automatic t_reset();
    chk("irq", 8'h01, {7'h00, irq_n});
    chk("pullups", 8'h00, {4'h0, pu_en});
    chk("col drive", 8'h00, {4'h0, col_oe});
    chk("col out", 8'h00, {4'h0, col_o});
    rd(ADDR_MAIN);
    chk("main", 8'h00, rd_v);
    rd(8'h30);
    chk("unmapped", 8'h00, rd_v);
  endtask

  task automatic t_cfg();
    wr(ADDR_PIN_MODE, 8'h30);
    wr(ADDR_ROW_PU, 8'h0F);
    wr(ADDR_PIN_FUNC, 8'hFF);
    wr(ADDR_DAY_CUR, 8'hA5);
    wr(ADDR_BL_WAKE, 8'h01);
    wr(ADDR_IRQ_EN, 8'h03);
    chk("pullups", 8'h0F, {4'h0, pu_en});
    chk("day cur", 8'hA5, day_cur);
    step(20);
    chk("standby drive", 8'h00, {4'h0, col_oe});
    wr(ADDR_MAIN, 8'h80);
  endtask

  task automatic t_press_a();
    keys = 16'h0001;
    wait_key(ADDR_STATE_LO, 8'h01);
    step(3);
    chk("irq press", 8'h00, {7'h00, irq_n});
    chk("backlight", 8'h01, {7'h00, bl_on});
    rd(ADDR_PRESS_LO);
    chk("press lo", 8'h01, rd_v);
    rd(ADDR_PRESS_LO);
    chk("press lo again", 8'h00, rd_v);
    rd(ADDR_MAIN);
    chk("main", 8'hC1, rd_v);
    keys = 16'h0000;
    wait_key(ADDR_STATE_LO, 8'h00);
    step(3);
    rd(ADDR_REL_LO);
    chk("rel lo", 8'h01, rd_v);
    rd(ADDR_MAIN);
    chk("main", 8'hC3, rd_v);
    wr(ADDR_MAIN, 8'hC1);
    rd(ADDR_MAIN);
    chk("main w1c", 8'hC2, rd_v);
    chk("irq held", 8'h00, {7'h00, irq_n});
    wr(ADDR_MAIN, 8'hC2);
    chk("irq free", 8'h01, {7'h00, irq_n});
    wr(ADDR_MAIN, 8'h80);
    chk("backlight off", 8'h00, {7'h00, bl_on});
  endtask

  // key P sits on row 3 and column 3; press interrupt masked
  task automatic t_mask_p();
    wr(ADDR_IRQ_EN, 8'h02);
    keys = 16'h8000;
    wait_key(ADDR_STATE_HI, 8'h80);
    step(3);
    chk("irq masked", 8'h01, {7'h00, irq_n});
    chk("rewake", 8'h01, {7'h00, bl_on});
    rd(ADDR_PRESS_HI);
    chk("press hi", 8'h80, rd_v);
    keys = 16'h0000;
    wait_key(ADDR_STATE_HI, 8'h00);
    step(3);
    chk("irq release", 8'h00, {7'h00, irq_n});
    rd(ADDR_REL_HI);
    chk("rel hi", 8'h80, rd_v);
    wr(ADDR_MAIN, 8'hC3);
    chk("irq clear", 8'h01, {7'h00, irq_n});
  endtask

  // row 3 and column 3 handed back, row 0 dropped from the matrix
  task automatic t_gate();
    logic [3:0] seen;
    seen = 4'h0;
    wr(ADDR_PIN_MODE, 8'h10);
    wr(ADDR_PIN_FUNC, 8'hFE);
    keys = 16'h8001;
    for (int i = 0; i < 60; i++) begin
      seen = seen | col_oe;
      step(1);
    end
    chk("col drive seen", 8'h07, {4'h0, seen});
    rd(ADDR_STATE_LO);
    chk("state lo gated", 8'h00, rd_v);
    rd(ADDR_STATE_HI);
    chk("state hi gated", 8'h00, rd_v);
    chk("irq quiet", 8'h01, {7'h00, irq_n});
    keys = 16'h0000;
  endtask

  initial begin
    step(4);
    resetn = 1'b1;
    step(1);
    t_reset();
    t_cfg();
    t_press_a();
    t_mask_p();
    t_gate();
    results();
  end
endmodule
